// *** rtl/window_threshold_cfg.sv ***
// Threshold, hysteresis and event-count registers for channels 4 to 6
//
// Overview of operation
// [R1] Upper high-limit byte is compared against the result's top eight bits.
// [R2] High-limit low nibble sits in band register bits 7-4, vs result 3:0.
// [R3] Low-limit low nibble sits in count register bits 7-4, vs result 3:0.
// [R4] Upper low-limit byte is compared against the result's top eight bits.
// [R5] Event count n in bits 3-0: alert after n+1 consecutive crossings.
// [R6] Band nibble shifted left three gives hysteresis on the lower seven bits.
// [R7] Upper high-limit byte resets to all ones.
// [R8] Upper low-limit byte resets to zero.
// [R9] Band register resets to 0xF0.
// [R10] Count register resets to zero.
// [R11] All fields but alert status (a written one clears it) are readable and writable and keep the written value.
// [R12] A flag clears only once the result is back inside by the hysteresis.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module window_threshold_cfg
	import wwin_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [wwin_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Conversion results
	input wire logic sample_valid_i,
	input wire logic [2:0] sample_ch_i,
	input wire logic [wwin_pkg::RES_W-1:0] sample_data_i,
	// Alerts
	output logic [wwin_pkg::NCH-1:0] alert_o,
	output logic irq_o
);
	import wwin_pkg::*;

	typedef struct packed {
		logic [NCH-1:0][7:0] hi_upper;
		logic [NCH-1:0][7:0] hi_band;
		logic [NCH-1:0][7:0] lo_count;
		logic [NCH-1:0][7:0] lo_upper;
		logic [NCH-1:0] status;
		logic [NCH-1:0] mask;
		logic [31:0] rdata;
		logic err;
	} regs_t;

	regs_t r_reg;
	regs_t r_next;

	logic [7:0] idx;
	logic aligned;
	logic setup;
	logic wr;
	logic mapped;
	logic hit_status;
	logic hit_mask;
	logic [31:0] rd;
	logic [NCH-1:0] hit_band;
	logic [NCH-1:0] hit_high;
	logic [NCH-1:0] hit_count;
	logic [NCH-1:0] hit_low;
	logic [NCH-1:0] alert_set;
	logic [NCH-1:0] clr_bits;

	// Address decode
	assign idx = paddr_i[9:2];
	assign aligned = (paddr_i[1:0] == 2'b00);
	assign setup = psel_i && !penable_i;
	assign wr = psel_i && penable_i && pwrite_i && pstrb_i[0];
	assign hit_status = aligned && (idx == IDX_ALERT_STATUS);
	assign hit_mask = aligned && (idx == IDX_ALERT_MASK);
	assign mapped = |{hit_band, hit_high, hit_count, hit_low,
		hit_status, hit_mask};

	// Per-channel decode, field mapping and comparator
	for (genvar k = 0; k < NCH; k++) begin : ch_g
		wcmp_if cif ();

		assign hit_band[k] = aligned && (idx == IDX_BAND[k]);
		assign hit_high[k] = aligned && (idx == IDX_HIGH[k]);
		assign hit_count[k] = aligned && (idx == IDX_COUNT[k]);
		assign hit_low[k] = aligned && (idx == IDX_LOW[k]);

		// Full limits: stored byte over stored nibble
		assign cif.hi_lim = {r_reg.hi_upper[k], // see R1
			r_reg.hi_band[k][NIB_POS +: NIB_W]}; // see R2
		assign cif.lo_lim = {r_reg.lo_upper[k], // see R4
			r_reg.lo_count[k][NIB_POS +: NIB_W]}; // see R3
		assign cif.band = r_reg.hi_band[k][NIB_W-1:0]; // see R6
		assign cif.count = r_reg.lo_count[k][NIB_W-1:0]; // see R5
		assign cif.valid = sample_valid_i &&
			(sample_ch_i == 3'(FIRST_CH + k));
		assign cif.data = sample_data_i;
		assign alert_set[k] = cif.alert_set;
		assign alert_o[k] = cif.flagged;

		window_cmp u_cmp (
			.clk_i(clk_i),
			.reset_i(reset_i),
			.bus(cif.cmp)
		);
	end

	// Read multiplexer
	always_comb begin
		rd = 32'h0000_0000;
		for (int k = 0; k < NCH; k++) begin
			if (hit_band[k]) rd[7:0] = r_reg.hi_band[k]; // see R11
			if (hit_high[k]) rd[7:0] = r_reg.hi_upper[k];
			if (hit_count[k]) rd[7:0] = r_reg.lo_count[k];
			if (hit_low[k]) rd[7:0] = r_reg.lo_upper[k];
		end
		if (hit_status) rd[NCH-1:0] = r_reg.status;
		if (hit_mask) rd[NCH-1:0] = r_reg.mask;
	end

	// Next state of the register file
	always_comb begin
		r_next = r_reg;
		for (int k = 0; k < NCH; k++) begin
			if (wr && hit_band[k]) r_next.hi_band[k] = pwdata_i[7:0]; // see R11
			if (wr && hit_high[k]) r_next.hi_upper[k] = pwdata_i[7:0];
			if (wr && hit_count[k]) r_next.lo_count[k] = pwdata_i[7:0];
			if (wr && hit_low[k]) r_next.lo_upper[k] = pwdata_i[7:0];
		end
		if (wr && hit_mask) r_next.mask = pwdata_i[NCH-1:0];
		// A new event wins over a clear in the same cycle
		clr_bits = (wr && hit_status) ? pwdata_i[NCH-1:0] : '0;
		r_next.status = (r_reg.status & ~clr_bits) | alert_set;
		// Read data and error are captured in the setup cycle
		if (setup) begin
			r_next.rdata = pwrite_i ? 32'h0000_0000 : rd;
			r_next.err = !mapped;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			r_reg.hi_upper <= {NCH{RST_HIGH_UPPER}}; // see R7
			r_reg.hi_band <= {NCH{RST_BAND}}; // see R9
			r_reg.lo_count <= {NCH{RST_COUNT}}; // see R10
			r_reg.lo_upper <= {NCH{RST_LOW_UPPER}}; // see R8
			r_reg.status <= RST_STATUS;
			r_reg.mask <= RST_MASK;
			r_reg.rdata <= 32'h0000_0000;
			r_reg.err <= 1'b0;
		end else begin
			r_reg <= r_next;
		end
	end

	// Bus answers: no wait states
	assign pready_o = 1'b1;
	assign pslverr_o = r_reg.err && psel_i && penable_i;
	assign prdata_o = r_reg.rdata;
	assign irq_o = |(r_reg.status & r_reg.mask);

	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);

	sequence setup_s(logic [7:0] i);
		psel_i && !penable_i && aligned && idx == i;
	endsequence

	sequence access_s;
		psel_i && penable_i;
	endsequence

	high_reset_a: assert property ( // see R7
		$fell(reset_i) |-> r_reg.hi_upper == {NCH{8'hFF}})
		else $error("upper high byte not all ones after reset");

	low_reset_a: assert property ( // see R8
		$fell(reset_i) |-> r_reg.lo_upper == '0)
		else $error("upper low byte not zero after reset");

	band_reset_a: assert property ( // see R9
		$fell(reset_i) |-> ch_g[0].cif.hi_lim == 12'hFFF &&
		ch_g[1].cif.band == 4'h0 && r_reg.hi_band[2] == 8'hF0)
		else $error("band register not 0xF0 after reset");

	count_reset_a: assert property ( // see R10
		$fell(reset_i) |-> ch_g[0].cif.lo_lim == 12'h000 &&
		ch_g[2].cif.count == 4'h0 && r_reg.lo_count == '0)
		else $error("count register not zero after reset");

	band_write_a: assert property ( // see R2
		(setup_s(IDX_CH4_HIGH_NIBBLE_AND_BAND) and pwrite_i) ##1
		(access_s and pstrb_i[0]) |=>
		ch_g[0].cif.hi_lim[3:0] == $past(pwdata_i[7:4]) &&
		ch_g[0].cif.band == $past(pwdata_i[3:0]))
		else $error("band register write not applied");

	count_write_a: assert property ( // see R3
		(setup_s(IDX_CH6_LOW_NIBBLE_AND_COUNT) and pwrite_i) ##1
		(access_s and pstrb_i[0]) |=>
		ch_g[2].cif.lo_lim[3:0] == $past(pwdata_i[7:4]) &&
		ch_g[2].cif.count == $past(pwdata_i[3:0]))
		else $error("count register write not applied");

	upper_write_a: assert property ( // see R1
		(setup_s(IDX_CH5_HIGH_LIMIT_UPPER) and pwrite_i) ##1
		(access_s and pstrb_i[0]) |=>
		ch_g[1].cif.hi_lim[11:4] == $past(pwdata_i[7:0]))
		else $error("upper high byte write not applied");

	read_back_a: assert property ( // see R11
		setup_s(IDX_CH4_LOW_LIMIT_UPPER) and !pwrite_i |=>
		prdata_o == {24'h00_0000, r_reg.lo_upper[0]} && !pslverr_o)
		else $error("read data does not match stored value");

	unmapped_a: assert property (
		psel_i && !penable_i && !mapped |=> penable_i |-> pslverr_o)
		else $error("unmapped access not flagged");

	event_irq_a: assert property (
		alert_set[0] && r_reg.mask[0] |=> irq_o && r_reg.status[0])
		else $error("unmasked event did not raise interrupt");

	clear_a: assert property (
		wr && hit_status && pwdata_i[1] && !alert_set[1] |=> !r_reg.status[1])
		else $error("status bit not cleared by writing one");

	// Bus-side checks shared by all channels
	sequence strobe_miss_s;
		psel_i && penable_i && pwrite_i && !pstrb_i[0];
	endsequence

	no_strobe_a: assert property ( // see R11
		strobe_miss_s |=> $stable(r_reg.hi_upper) &&
		$stable(r_reg.hi_band) && $stable(r_reg.lo_count) &&
		$stable(r_reg.lo_upper) && $stable(r_reg.mask))
		else $error("write without byte strobe changed a register");

	mask_write_a: assert property (
		wr && hit_mask |=> r_reg.mask == $past(pwdata_i[NCH-1:0]))
		else $error("mask register write not applied");

	status_reset_a: assert property (
		$fell(reset_i) |-> r_reg.status == RST_STATUS &&
		r_reg.mask == RST_MASK && !irq_o && alert_o == '0)
		else $error("status, mask or alerts not clear after reset");

	ready_a: assert property (
		access_s |-> pready_o)
		else $error("access phase stretched by a wait state");

	err_window_a: assert property (
		!(psel_i && penable_i) |-> !pslverr_o)
		else $error("error shown outside an access phase");

	unmapped_zero_a: assert property (
		psel_i && !penable_i && !pwrite_i && !mapped |=>
		prdata_o == '0)
		else $error("unmapped read returned data");

	upper_zero_a: assert property ( // see R11
		psel_i && !penable_i |=> prdata_o[31:8] == 24'h00_0000)
		else $error("unused read data bits not zero");

	irq_quiet_a: assert property (
		(r_reg.status & r_reg.mask) == '0 |-> !irq_o)
		else $error("interrupt high with no unmasked status bit");

	// Per-channel register, status and alert checks
	for (genvar k = 0; k < NCH; k++) begin : chk_g
		high_store_a: assert property ( // see R1
			wr && hit_high[k] |=>
			r_reg.hi_upper[k] == $past(pwdata_i[7:0]))
			else $error("upper high byte write not stored");

		band_store_a: assert property ( // see R2
			wr && hit_band[k] |=>
			r_reg.hi_band[k] == $past(pwdata_i[7:0]))
			else $error("band register write not stored");

		count_store_a: assert property ( // see R3
			wr && hit_count[k] |=>
			r_reg.lo_count[k] == $past(pwdata_i[7:0]))
			else $error("count register write not stored");

		low_store_a: assert property ( // see R4
			wr && hit_low[k] |=>
			r_reg.lo_upper[k] == $past(pwdata_i[7:0]))
			else $error("upper low byte write not stored");

		field_hold_a: assert property ( // see R11
			!(wr && (hit_band[k] || hit_high[k] ||
			hit_count[k] || hit_low[k])) |=>
			$stable(r_reg.hi_upper[k]) && $stable(r_reg.hi_band[k]) &&
			$stable(r_reg.lo_count[k]) && $stable(r_reg.lo_upper[k]))
			else $error("register changed without a write");

		high_read_a: assert property ( // see R11
			setup_s(IDX_HIGH[k]) and !pwrite_i |=>
			prdata_o[7:0] == r_reg.hi_upper[k])
			else $error("upper high byte read back wrong");

		band_read_a: assert property ( // see R11
			setup_s(IDX_BAND[k]) and !pwrite_i |=>
			prdata_o[7:0] == r_reg.hi_band[k])
			else $error("band register read back wrong");

		count_read_a: assert property ( // see R11
			setup_s(IDX_COUNT[k]) and !pwrite_i |=>
			prdata_o[7:0] == r_reg.lo_count[k])
			else $error("count register read back wrong");

		low_read_a: assert property ( // see R11
			setup_s(IDX_LOW[k]) and !pwrite_i |=>
			prdata_o[7:0] == r_reg.lo_upper[k])
			else $error("upper low byte read back wrong");

		status_set_a: assert property ( // see R5
			alert_set[k] |=> r_reg.status[k])
			else $error("alert event did not set its status bit");

		status_keep_a: assert property (
			r_reg.status[k] && !(wr && hit_status && pwdata_i[k]) |=>
			r_reg.status[k])
			else $error("status bit dropped without a clear");

		status_quiet_a: assert property (
			!r_reg.status[k] && !alert_set[k] |=> !r_reg.status[k])
			else $error("status bit set without an event");

		irq_raise_a: assert property (
			alert_set[k] && r_reg.mask[k] |=> irq_o)
			else $error("unmasked event did not raise interrupt");

		alert_cause_a: assert property ( // see R5
			$rose(alert_o[k]) |-> $past(ch_g[k].cif.valid))
			else $error("alert rose without a sample");

		alert_clear_a: assert property ( // see R12
			$fell(alert_o[k]) |-> $past(ch_g[k].cif.valid))
			else $error("alert cleared without a sample");
	end
endmodule : window_threshold_cfg
`default_nettype wire

// *** rtl/wwin_pkg.sv ***
// Constants for the window threshold configuration block
package wwin_pkg;
	localparam int NCH = 3;
	localparam int FIRST_CH = 4;
	localparam int ADDR_W = 10;
	localparam int RES_W = 12;
	localparam int NIB_POS = 4;
	localparam int NIB_W = 4;
	localparam int HYST_SHIFT = 3;
	localparam logic [11:0] FULL_SCALE = 12'hFFF;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_CH4_HIGH_NIBBLE_AND_BAND = 8'h30;
	localparam logic [7:0] IDX_CH4_HIGH_LIMIT_UPPER = 8'h31;
	localparam logic [7:0] IDX_CH4_LOW_NIBBLE_AND_COUNT = 8'h32;
	localparam logic [7:0] IDX_CH4_LOW_LIMIT_UPPER = 8'h33;
	localparam logic [7:0] IDX_CH5_HIGH_NIBBLE_AND_BAND = 8'h34;
	localparam logic [7:0] IDX_CH5_HIGH_LIMIT_UPPER = 8'h35;
	localparam logic [7:0] IDX_CH5_LOW_NIBBLE_AND_COUNT = 8'h36;
	localparam logic [7:0] IDX_CH5_LOW_LIMIT_UPPER = 8'h37;
	localparam logic [7:0] IDX_CH6_HIGH_NIBBLE_AND_BAND = 8'h38;
	localparam logic [7:0] IDX_CH6_HIGH_LIMIT_UPPER = 8'h39;
	localparam logic [7:0] IDX_CH6_LOW_NIBBLE_AND_COUNT = 8'h3A;
	localparam logic [7:0] IDX_CH6_LOW_LIMIT_UPPER = 8'h3B;
	localparam logic [7:0] IDX_ALERT_STATUS = 8'h40;
	localparam logic [7:0] IDX_ALERT_MASK = 8'h41;
	localparam logic [NCH-1:0][7:0] IDX_BAND = {IDX_CH6_HIGH_NIBBLE_AND_BAND,
		IDX_CH5_HIGH_NIBBLE_AND_BAND, IDX_CH4_HIGH_NIBBLE_AND_BAND};
	localparam logic [NCH-1:0][7:0] IDX_HIGH = {IDX_CH6_HIGH_LIMIT_UPPER,
		IDX_CH5_HIGH_LIMIT_UPPER, IDX_CH4_HIGH_LIMIT_UPPER};
	localparam logic [NCH-1:0][7:0] IDX_COUNT = {IDX_CH6_LOW_NIBBLE_AND_COUNT,
		IDX_CH5_LOW_NIBBLE_AND_COUNT, IDX_CH4_LOW_NIBBLE_AND_COUNT};
	localparam logic [NCH-1:0][7:0] IDX_LOW = {IDX_CH6_LOW_LIMIT_UPPER,
		IDX_CH5_LOW_LIMIT_UPPER, IDX_CH4_LOW_LIMIT_UPPER};
	// Values after reset
	localparam logic [7:0] RST_HIGH_UPPER = 8'hFF;
	localparam logic [7:0] RST_BAND = 8'hF0;
	localparam logic [7:0] RST_COUNT = 8'h00;
	localparam logic [7:0] RST_LOW_UPPER = 8'h00;
	localparam logic [NCH-1:0] RST_STATUS = 3'h0;
	localparam logic [NCH-1:0] RST_MASK = 3'h0;
endpackage : wwin_pkg

// *** rtl/wcmp_if.sv ***
// Carrier between the register file and one channel comparator
`timescale 1ns/1ps
`default_nettype none
interface wcmp_if;
	logic [11:0] hi_lim;
	logic [11:0] lo_lim;
	logic [3:0] band;
	logic [3:0] count;
	logic valid;
	logic [11:0] data;
	logic alert_set;
	logic flagged;
	modport ctl (output hi_lim, lo_lim, band, count, valid, data,
		input alert_set, flagged);
	modport cmp (input hi_lim, lo_lim, band, count, valid, data,
		output alert_set, flagged);
endinterface : wcmp_if
`default_nettype wire

// *** rtl/window_cmp.sv ***
// Window comparator with event count and hysteresis for one channel
`timescale 1ns/1ps
`default_nettype none
module window_cmp
	import wwin_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Configuration, samples and results
	wcmp_if.cmp bus
);
	typedef struct packed {
		logic [3:0] cnt;
		logic hi_flag;
		logic lo_flag;
		logic alert_set;
	} cmp_state_t;

	cmp_state_t st_reg;
	cmp_state_t st_next;
	logic [11:0] hys;
	logic [11:0] h_rel;
	logic [11:0] l_rel;
	logic above;
	logic below;

	always_comb begin
		hys = 12'(bus.band) << HYST_SHIFT; // see R6
		h_rel = (bus.hi_lim >= hys) ? bus.hi_lim - hys : 12'h000;
		l_rel = (FULL_SCALE - bus.lo_lim >= hys) ? bus.lo_lim + hys : FULL_SCALE;
		above = bus.data > bus.hi_lim;
		below = bus.data < bus.lo_lim;
		st_next = st_reg;
		st_next.alert_set = 1'b0;
		if (bus.valid) begin
			if (st_reg.hi_flag) begin
				if (bus.data < h_rel) st_next.hi_flag = 1'b0; // see R12
			end else if (st_reg.lo_flag) begin
				if (bus.data > l_rel) st_next.lo_flag = 1'b0; // see R12
			end else if (above || below) begin
				if (st_reg.cnt == bus.count) begin // see R5
					st_next.hi_flag = above;
					st_next.lo_flag = below;
					st_next.alert_set = 1'b1;
					st_next.cnt = 4'h0;
				end else begin
					st_next.cnt = st_reg.cnt + 4'h1;
				end
			end else begin
				st_next.cnt = 4'h0;
			end
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) st_reg <= '0;
		else st_reg <= st_next;
	end

	assign bus.alert_set = st_reg.alert_set;
	assign bus.flagged = st_reg.hi_flag | st_reg.lo_flag;

	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);

	sequence idle_cross_s;
		bus.valid && !bus.flagged && (above || below);
	endsequence

	no_early_set_a: assert property ( // see R5
		idle_cross_s and st_reg.cnt != bus.count |=> !bus.flagged)
		else $error("alert set before n+1 crossings");
	set_on_count_a: assert property ( // see R5
		idle_cross_s and st_reg.cnt == bus.count |=> bus.alert_set ##1 !bus.alert_set)
		else $error("alert not set after n+1 crossings");
	hyst_hold_a: assert property ( // see R12
		st_reg.hi_flag && bus.valid && bus.data >= bus.hi_lim - (12'(bus.band) << 3)
		&& bus.hi_lim >= (12'(bus.band) << 3) |=> st_reg.hi_flag)
		else $error("high flag cleared inside hysteresis band");
	hyst_clear_a: assert property ( // see R12
		st_reg.lo_flag && bus.valid && bus.data > l_rel |=> !st_reg.lo_flag)
		else $error("low flag kept after leaving band");
endmodule : window_cmp
`default_nettype wire

// *** verif/window_threshold_cfg_bench.sv ***
// Self-checking bench for the channel 4 to 6 window threshold block
`timescale 1ns/1ps
`default_nettype none
module window_threshold_cfg_bench;
	import wwin_pkg::*;
	typedef struct packed {
		logic err;
		logic [31:0] data;
		logic [2:0] alert;
		logic irq;
	} note_t;
	logic clk_i = 1'h0;
	logic reset_i = 1'h1;
	logic psel_i = 1'h0;
	logic penable_i = 1'h0;
	logic pwrite_i = 1'h0;
	logic [9:0] paddr_i = 10'h000;
	logic [31:0] pwdata_i = 32'h0000_0000;
	logic [3:0] pstrb_i = 4'h0;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic sample_valid_i = 1'h0;
	logic [2:0] sample_ch_i = 3'h0;
	logic [11:0] sample_data_i = 12'h000;
	logic [2:0] alert_o;
	logic irq_o;
	note_t notes[$];
	note_t cur;
	logic [2:0] ea = 3'h0;
	logic ei = 1'h0;
	logic [31:0] seed = 32'h0000_673A;
	logic [31:0] r;
	logic [7:0] shadow[12];
	int miscompares = 0;
	int checks = 0;
	int cycles = 0;

	window_threshold_cfg dut (
		.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o),
		.sample_valid_i(sample_valid_i), .sample_ch_i(sample_ch_i),
		.sample_data_i(sample_data_i), .alert_o(alert_o), .irq_o(irq_o)
	);

	initial begin
		forever #2.5 clk_i = ~clk_i;
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD at %0t seen %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic stop_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : stop_test

	// One APB transfer; the request holds until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] idx,
			input logic [31:0] wd, input logic [3:0] strb);
		@(posedge clk_i);
		psel_i <= 1'h1;
		penable_i <= 1'h0;
		pwrite_i <= wr;
		paddr_i <= {idx, 2'h0};
		pwdata_i <= wd;
		pstrb_i <= strb;
		@(posedge clk_i);
		penable_i <= 1'h1;
		do begin
			@(posedge clk_i);
		end while (pready_o !== 1'h1);
		psel_i <= 1'h0;
		penable_i <= 1'h0;
	endtask : apb

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		apb(1'h1, idx, {24'h00_0000, d}, 4'hF);
	endtask : wr

	task automatic rd(input logic [7:0] idx, input logic [7:0] d,
			input logic err);
		notes.push_back('{err, {24'h00_0000, d}, ea, ei});
		apb(1'h0, idx, 32'h0000_0000, 4'h0);
	endtask : rd

	task automatic smp(input logic [2:0] ch, input logic [11:0] d,
			input int n);
		repeat (n) begin
			@(posedge clk_i);
			sample_valid_i <= 1'h1;
			sample_ch_i <= ch;
			sample_data_i <= d;
		end
		@(posedge clk_i);
		sample_valid_i <= 1'h0;
		repeat (3) @(posedge clk_i);
	endtask : smp

	// Compares every completed read against the oldest note
	always @(posedge clk_i) begin
		if (psel_i && penable_i && !pwrite_i && pready_o === 1'h1) begin
			if (notes.size() == 0) begin
				check(32'h0000_0000, 32'h0000_0001);
			end else begin
				cur = notes.pop_front();
				check(prdata_o, cur.data);
				check({31'h0, pslverr_o}, {31'h0, cur.err});
				check({29'h0, alert_o}, {29'h0, cur.alert});
				check({31'h0, irq_o}, {31'h0, cur.irq});
			end
		end
	end

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			stop_test();
		end
	end

	initial begin
		repeat (12) @(posedge clk_i);
		reset_i <= 1'h0;
		for (int c = 0; c < NCH; c++) begin
			rd(IDX_BAND[c], RST_BAND, 1'h0);
			rd(IDX_HIGH[c], RST_HIGH_UPPER, 1'h0);
			rd(IDX_COUNT[c], RST_COUNT, 1'h0);
			rd(IDX_LOW[c], RST_LOW_UPPER, 1'h0);
		end
		rd(IDX_ALERT_STATUS, 8'h00, 1'h0);
		rd(IDX_ALERT_MASK, 8'h00, 1'h0);
		$display("test reset values done");
		for (int i = 0; i < 12; i++) begin
			r = xs();
			shadow[i] = r[7:0];
			apb(1'h1, 8'h30 + 8'(i), r, 4'hF);
			apb(1'h1, 8'h30 + 8'(i), ~r, 4'h0);
		end
		for (int i = 0; i < 12; i++) begin
			rd(8'h30 + 8'(i), shadow[i], 1'h0);
		end
		rd(8'h3C, 8'h00, 1'h1);
		$display("test read write done");
		wr(IDX_CH4_HIGH_LIMIT_UPPER, 8'h7A);
		wr(IDX_CH4_HIGH_NIBBLE_AND_BAND, 8'h52);
		wr(IDX_CH4_LOW_NIBBLE_AND_COUNT, 8'h02);
		wr(IDX_CH4_LOW_LIMIT_UPPER, 8'h00);
		wr(IDX_ALERT_MASK, 8'h01);
		smp(3'h4, 12'h7A5, 4);
		smp(3'h4, 12'h7A6, 2);
		smp(3'h4, 12'h7A5, 1);
		smp(3'h4, 12'h7A6, 2);
		rd(IDX_ALERT_STATUS, 8'h00, 1'h0);
		smp(3'h4, 12'h7A6, 1);
		ea = 3'h1;
		ei = 1'h1;
		rd(IDX_ALERT_STATUS, 8'h01, 1'h0);
		wr(IDX_ALERT_MASK, 8'h01);
		smp(3'h4, 12'h795, 1);
		rd(IDX_ALERT_MASK, 8'h01, 1'h0);
		smp(3'h4, 12'h794, 1);
		ea = 3'h0;
		rd(IDX_ALERT_STATUS, 8'h01, 1'h0);
		wr(IDX_ALERT_STATUS, 8'h01);
		ei = 1'h0;
		rd(IDX_ALERT_STATUS, 8'h00, 1'h0);
		$display("test high limit done");
		wr(IDX_CH5_LOW_LIMIT_UPPER, 8'h3C);
		wr(IDX_CH5_LOW_NIBBLE_AND_COUNT, 8'h70);
		wr(IDX_CH5_HIGH_NIBBLE_AND_BAND, 8'hF1);
		wr(IDX_CH5_HIGH_LIMIT_UPPER, 8'hFF);
		wr(IDX_ALERT_MASK, 8'h03);
		smp(3'h5, 12'h3C7, 1);
		rd(IDX_ALERT_STATUS, 8'h00, 1'h0);
		smp(3'h5, 12'h3C6, 1);
		ea = 3'h2;
		ei = 1'h1;
		rd(IDX_ALERT_STATUS, 8'h02, 1'h0);
		smp(3'h5, 12'h3CF, 1);
		rd(IDX_ALERT_STATUS, 8'h02, 1'h0);
		smp(3'h5, 12'h3D0, 1);
		ea = 3'h0;
		wr(IDX_ALERT_STATUS, 8'h02);
		ei = 1'h0;
		rd(IDX_ALERT_STATUS, 8'h00, 1'h0);
		$display("test low limit done");
		wr(IDX_CH6_HIGH_NIBBLE_AND_BAND, RST_BAND);
		wr(IDX_CH6_HIGH_LIMIT_UPPER, RST_HIGH_UPPER);
		wr(IDX_CH6_LOW_NIBBLE_AND_COUNT, RST_COUNT);
		wr(IDX_CH6_LOW_LIMIT_UPPER, RST_LOW_UPPER);
		wr(IDX_ALERT_MASK, 8'h07);
		wr(IDX_CH6_LOW_LIMIT_UPPER, 8'h10);
		smp(3'h6, 12'h0FF, 1);
		ea = 3'h4;
		ei = 1'h1;
		rd(IDX_ALERT_STATUS, 8'h04, 1'h0);
		smp(3'h6, 12'h101, 1);
		ea = 3'h0;
		wr(IDX_ALERT_STATUS, 8'h04);
		wr(IDX_CH6_LOW_LIMIT_UPPER, RST_LOW_UPPER);
		ei = 1'h0;
		rd(IDX_ALERT_STATUS, 8'h00, 1'h0);
		$display("test channel six done");
		for (int i = 0; i < 40; i++) begin
			r = xs();
			smp((r[2:1] == 2'h2) ? 3'h7 : r[2:0], r[23:12], 1);
		end
		rd(IDX_ALERT_STATUS, 8'h00, 1'h0);
		$display("test random samples done");
		repeat (5) @(posedge clk_i);
		stop_test();
	end
endmodule : window_threshold_cfg_bench
`default_nettype wire
